// [hw/closed_loop_mode_select.sv]
`timescale 1ns/100ps
// Function
// - Closed loop needs submode bit 0, which the block sets itself when an auto setup succeeds.
// - With a Hall commutation sensor, closed loop is entered right after power-up.
// - With encoder commutation, open loop holds until the index has been seen once or an alignment has finished.
// - With submode bit 4 set and encoder commutation, alignment runs once per restart on the first enable-operation command unless the index was already seen.
// - Alignment moves the rotor to a pole, then operation enabled is entered and motion resumes.
// - Status bit 15 shows closed loop while operation is enabled.
// - Speed is the position change per cycle, low-pass filtered.
// - Slow speed is available only with encoder feedback.
// - Slow speed and closed loop swap at a programmable threshold with 10 percent hysteresis.
// - Slow speed drives constant current but still watches following error and may enable vector control.
// - At standstill with slow speed enabled, closed loop is used.
// - With several commutation sensors, the one with valid alignment is used.
module closed_loop_mode_select
  import mode_sel_pkg::*;
#(
  parameter int AlignCount = AlignCycles
)
(
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        encIndex,
  input  wire logic signed [15:0] encDelta,
  input  wire logic        autoSetupDone,
  input  wire logic        followErr,
  output logic             closedLoop,
  output logic             slowSpeed,
  output logic             alignDrive,
  output logic             vectorCtrl,
  output logic             commutHall,
  output logic             opEnabled
);
  speed_if sp ();

  logic [15:0] submode_r;
  logic [1:0]  sensor_r;
  logic [15:0] thresh_r;
  logic [2:0]  idxSync_r;
  logic        idxSeen_r;
  logic        aligned_r;
  logic        alignDone_r;
  logic [31:0] alignCnt_r;
  logic        slowSel_r;
  logic        enableReq_r;
  pwr_state_t  pwr_r;
  pwr_state_t  pwr_nxt;
  logic        hallOk;
  logic        encOk;
  logic        clAllowed;
  logic        wbHit;
  logic        wbWr;
  logic        closedNow;
  logic [15:0] hiLimit;
  logic [15:0] loLimit;
  logic [15:0] statusWord;
  logic [31:0] rdData;

  function automatic logic [15:0] scale_pct(input logic [15:0] v, input int pct);
    logic [23:0] p;
    p = 24'(v) * 24'(pct);
    return 16'(p / 24'd100);
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    merge16 = old;
    if (s[0]) merge16[7:0] = d[7:0];
    if (s[1]) merge16[15:8] = d[15:8];
  endfunction

  assign sp.posDelta = encDelta;
  assign sp.sample   = 1'b1;

  speed_estimator u_speed (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .ce      (ce),
    .sp      (sp)
  );

  assign wbHit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Writes land at the edge where the master sees ack, so a request dropped earlier leaves no trace.
  assign wbWr  = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

  // Single-cycle answer; unmapped addresses read zero and ignore writes.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else if (ce) begin
      wb_ack_o <= wbHit;
      wb_dat_o <= rdData;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      submode_r <= SubmodeReset;
    end else if (ce) begin
      if (wbWr && wb_adr_i == SubmodeOffset) begin
        submode_r <= merge16(submode_r, wb_dat_i, wb_sel_i);
      end
      if (autoSetupDone) begin
        submode_r[SubClosedLoopBit] <= 1'b1;
        submode_r[SubAutoSetupBit]  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sensor_r <= SensorReset;
      thresh_r <= ThreshReset;
    end else if (ce && wbWr) begin
      if (wb_adr_i == SensorOffset && wb_sel_i[0]) begin
        sensor_r <= wb_dat_i[1:0];
      end
      if (wb_adr_i == ThreshOffset) begin
        thresh_r <= merge16(thresh_r, wb_dat_i, wb_sel_i);
      end
    end
  end

  // The enable-operation request is a level that stands until a write of 0 withdraws it.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      enableReq_r <= 1'b0;
    end else if (ce) begin
      if (wbWr && wb_adr_i == PowerCmdOffset && wb_sel_i[0]) begin
        enableReq_r <= wb_dat_i[0];
      end
    end
  end

  // Index pin synchroniser; a pulse counts once stages two and three are both high.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      idxSync_r <= 3'h0;
      idxSeen_r <= 1'b0;
    end else if (ce) begin
      idxSync_r <= {idxSync_r[1:0], encIndex};
      if (idxSync_r[1] && idxSync_r[2]) begin
        idxSeen_r <= 1'b1;
      end
    end
  end

  assign hallOk = sensor_r[SenHallSelBit];
  assign encOk  = sensor_r[SenEncSelBit] && (idxSeen_r || aligned_r);
  assign clAllowed = submode_r[SubClosedLoopBit] && (hallOk || encOk);

  always_comb begin
    pwr_nxt = pwr_r;
    case (pwr_r)
      PwrIdle: begin
        if (enableReq_r) begin
          // Alignment is only needed when no sensor already gives it.
          if (submode_r[SubAutoAlignBit] && !alignDone_r && !hallOk && !idxSeen_r) begin
            pwr_nxt = PwrAlign;
          end else begin
            pwr_nxt = PwrEnabled;
          end
        end
      end
      PwrAlign: begin
        if (!enableReq_r) begin
          pwr_nxt = PwrIdle;
        end else if (alignCnt_r == 32'(AlignCount - 1)) begin
          pwr_nxt = PwrEnabled;
        end
      end
      PwrEnabled: begin
        if (!enableReq_r) begin
          pwr_nxt = PwrIdle;
        end
      end
      default: pwr_nxt = PwrIdle;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pwr_r <= PwrIdle;
    end else if (ce) begin
      pwr_r <= pwr_nxt;
    end
  end

  // Alignment runs once per restart; a dropped enable does not retry it.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      alignCnt_r  <= 32'h0;
      alignDone_r <= 1'b0;
      aligned_r   <= 1'b0;
    end else if (ce) begin
      if (pwr_r == PwrAlign) begin
        alignCnt_r <= alignCnt_r + 32'h1;
        if (alignCnt_r == 32'(AlignCount - 1)) begin
          aligned_r <= 1'b1;
        end
      end else begin
        alignCnt_r <= 32'h0;
      end
      if (pwr_r == PwrAlign) begin
        alignDone_r <= 1'b1;
      end
    end
  end

  assign hiLimit = thresh_r + scale_pct(thresh_r, HystPercent);
  assign loLimit = thresh_r - scale_pct(thresh_r, HystPercent);

  // Standstill is caught before the limit checks, so it always returns to closed loop.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      slowSel_r <= 1'b0;
    end else if (ce) begin
      if (!submode_r[SubSlowSpeedBit] || !sensor_r[SenEncSelBit] || !clAllowed) begin
        slowSel_r <= 1'b0;
      end else if (sp.speedAbs == 16'h0) begin
        slowSel_r <= 1'b0;
      end else if (!slowSel_r && sp.speedAbs <= loLimit) begin
        slowSel_r <= 1'b1;
      end else if (slowSel_r && sp.speedAbs >= hiLimit) begin
        slowSel_r <= 1'b0;
      end
    end
  end

  // Slow speed drives a fixed current, so it does not count as closed loop in the status word.
  assign closedNow  = clAllowed && !slowSel_r;
  assign statusWord = StatOpEnabled
                    | ({15'h0, closedNow && (pwr_r == PwrEnabled)} << StatClosedLoopBit);

  always_comb begin
    rdData = 32'h0;
    case (wb_adr_i)
      SubmodeOffset:  rdData = {16'h0, submode_r};
      PowerCmdOffset: rdData = {31'h0, enableReq_r};
      SensorOffset:   rdData = {28'h0, idxSeen_r, aligned_r, sensor_r};
      ThreshOffset:   rdData = {16'h0, thresh_r};
      StatusOffset:   rdData = (pwr_r == PwrEnabled) ? {16'h0, statusWord} : {30'h0, pwr_r};
      SpeedOffset:    rdData = {16'h0, sp.speedAbs};
      default:        rdData = 32'h0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      closedLoop <= 1'b0;
      slowSpeed  <= 1'b0;
      alignDrive <= 1'b0;
      vectorCtrl <= 1'b0;
      commutHall <= 1'b0;
      opEnabled  <= 1'b0;
    end else if (ce) begin
      closedLoop <= closedNow;
      slowSpeed  <= slowSel_r;
      alignDrive <= pwr_r == PwrAlign;
      vectorCtrl <= clAllowed && (!slowSel_r || followErr);
      commutHall <= hallOk && !encOk;
      opEnabled  <= pwr_r == PwrEnabled;
    end
  end
endmodule

// [hw/mode_sel_pkg.sv]
package mode_sel_pkg;
  // Register byte offsets.
  localparam logic [7:0] SubmodeOffset  = 8'h00;
  localparam logic [7:0] PowerCmdOffset = 8'h04;
  localparam logic [7:0] SensorOffset   = 8'h08;
  localparam logic [7:0] ThreshOffset   = 8'h0c;
  localparam logic [7:0] StatusOffset   = 8'h10;
  localparam logic [7:0] SpeedOffset    = 8'h14;
  // Submode select fields.
  localparam int SubClosedLoopBit = 0;
  localparam int SubAutoAlignBit  = 4;
  localparam int SubSlowSpeedBit  = 7;
  localparam int SubAutoSetupBit  = 8;
  // Sensor configuration fields.
  localparam int SenHallSelBit = 0;
  localparam int SenEncSelBit  = 1;
  // Status word bit that shows closed loop.
  localparam int StatClosedLoopBit = 15;
  localparam logic [15:0] StatOpEnabled = 16'h0027;
  // Reset values.
  localparam logic [15:0] SubmodeReset = 16'h0000;
  localparam logic [1:0]  SensorReset  = 2'h2;
  localparam logic [15:0] ThreshReset  = 16'h0064;
  // Hysteresis in percent and filter shift.
  localparam int HystPercent = 10;
  localparam int FiltShift   = 3;
  // Alignment hold time.
  localparam int AlignTimeUs     = 100;
  localparam int ClkMhz          = 100;
  localparam int AlignCycles     = AlignTimeUs * ClkMhz;
  typedef enum logic [1:0] {
    PwrIdle    = 2'b00,
    PwrAlign   = 2'b01,
    PwrEnabled = 2'b11
  } pwr_state_t;
endpackage

// [hw/speed_if.sv]
`timescale 1ns/100ps
interface speed_if;
  logic signed [15:0] posDelta;
  logic               sample;
  logic        [15:0] speedAbs;
  modport est (input posDelta, input sample, output speedAbs);
  modport ctl (output posDelta, output sample, input speedAbs);
endinterface

// [hw/speed_estimator.sv]
`timescale 1ns/100ps
module speed_estimator
  import mode_sel_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  speed_if.est     sp
);
  logic signed [19:0] filt_r;
  logic signed [19:0] sum;
  logic        [19:0] mag;

  // Delta per fixed cycle is the speed; a first-order low-pass smooths it.
  // The filter settles at eight times the delta, and the output shift takes that gain back out.
  assign sum = filt_r + 20'(sp.posDelta) - (filt_r >>> FiltShift);
  assign mag = filt_r[19] ? 20'(-filt_r) : filt_r;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      filt_r <= 20'sh0;
    end else if (ce && sp.sample) begin
      filt_r <= sum;
    end
  end

  assign sp.speedAbs = 16'(mag >> FiltShift);
endmodule

// [verif/closed_loop_mode_select_asserts.sv]
`timescale 1ns/100ps
module closed_loop_mode_select_asserts
  import mode_sel_pkg::*;
#(
  parameter int AlignCount = 20
)
(
  input wire logic               clk_sys,
  input wire logic               rstn,
  input wire logic               ce,
  input wire logic               wb_cyc_i,
  input wire logic               wb_stb_i,
  input wire logic               wb_we_i,
  input wire logic [7:0]         wb_adr_i,
  input wire logic [31:0]        wb_dat_o,
  input wire logic               wb_ack_o,
  input wire logic signed [15:0] encDelta,
  input wire logic               followErr,
  input wire logic               closedLoop,
  input wire logic               slowSpeed,
  input wire logic               alignDrive,
  input wire logic               vectorCtrl,
  input wire logic               opEnabled
);
  logic [1:0] alignRuns;
  logic [8:0] stillCnt;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Counts alignment runs since the last restart.
  always_ff @(posedge clk_sys) begin
    if (!rstn) alignRuns <= 2'h0;
    else if ($rose(alignDrive) && alignRuns != 2'h3) alignRuns <= alignRuns + 2'h1;
  end
  // Counts cycles at standstill; 100 is well past the settling time of the speed filter.
  always_ff @(posedge clk_sys) begin
    if (!rstn || encDelta != 16'sh0) stillCnt <= 9'h0;
    else if (stillCnt != 9'h064) stillCnt <= stillCnt + 9'h1;
  end
  chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce |=> wb_ack_o) else $error("no ack");
  chk_ack_single: assert property (wb_ack_o && ce |=> !wb_ack_o) else $error("ack too long");
  chk_reset_quiet: assert property ($rose(rstn) |-> !opEnabled && !closedLoop && !alignDrive) else $error("not idle");
  chk_align_once: assert property (alignRuns < 2'h2) else $error("second alignment");
  chk_align_open: assert property (alignDrive |-> !closedLoop) else $error("closed loop in alignment");
  chk_align_ends: assert property ($rose(alignDrive) |-> alignDrive[*8] ##[1:40] (!alignDrive && opEnabled))
    else $error("alignment end");
  chk_status_bit: assert property (wb_ack_o && !wb_we_i && wb_adr_i == StatusOffset && opEnabled
    |-> wb_dat_o[15:0] == (StatOpEnabled | {closedLoop, 15'h0})) else $error("status word");
  chk_vector_err: assert property (slowSpeed && followErr |-> ##[1:2] vectorCtrl) else $error("no vector");
  chk_still_closed: assert property (stillCnt == 9'h064 |-> !slowSpeed) else $error("slow at rest");
  cover property ($rose(alignDrive));
  cover property ($rose(slowSpeed));
  cover property (slowSpeed && vectorCtrl);
endmodule

// [verif/motor_model.sv]
`timescale 1ns/100ps
module motor_model (
  input  wire logic               clk_sys,
  input  wire logic signed [15:0] speedCmd,
  input  wire logic               errCmd,
  output logic                    encIndex,
  output logic signed [15:0]      encDelta,
  output logic                    followErr
);
  logic [15:0] pos_r = 16'h0;
  logic [15:0] pos_nxt;
  logic [1:0]  idxHold_r = 2'h0;
  assign pos_nxt = pos_r + speedCmd;
  // One index pulse per 1024 counts, as an encoder gives once per turn. It lasts four
  // cycles, since the block's pin filter ignores anything shorter than two.
  always_ff @(posedge clk_sys) begin
    pos_r     <= pos_nxt;
    if (pos_r[15:10] != pos_nxt[15:10]) idxHold_r <= 2'h3;
    else if (idxHold_r != 2'h0) idxHold_r <= idxHold_r - 2'h1;
    encIndex  <= pos_r[15:10] != pos_nxt[15:10] || idxHold_r != 2'h0;
    encDelta  <= speedCmd;
    followErr <= errCmd;
  end
endmodule

// [verif/closed_loop_mode_select_test.sv]
`timescale 1ns/100ps
module closed_loop_mode_select_test
  import mode_sel_pkg::*;
;
  logic clk_sys = 0, rstn = 0, cyc = 0, stb = 0, we = 0, ack, setup = 0, errCmd = 0, ce = 1;
  logic [7:0] adr = 8'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic signed [15:0] speedCmd = 16'sh0, encDelta;
  logic encIndex, followErr, closedLoop, slowSpeed, alignDrive, vectorCtrl, commutHall, opEnabled;
  logic [15:0] rnd = 16'h63;
  int failures = 0, n_checks = 0;
  always #5 clk_sys = ~clk_sys;
  closed_loop_mode_select #(.AlignCount(20)) closed_loop_mode_select_inst (.clk_sys(clk_sys), .rstn(rstn),
    .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .encIndex(encIndex), .encDelta(encDelta), .autoSetupDone(setup),
    .followErr(followErr), .closedLoop(closedLoop), .slowSpeed(slowSpeed), .alignDrive(alignDrive),
    .vectorCtrl(vectorCtrl), .commutHall(commutHall), .opEnabled(opEnabled));
  motor_model motor_model_inst (.clk_sys(clk_sys), .speedCmd(speedCmd), .errCmd(errCmd), .encIndex(encIndex),
    .encDelta(encDelta), .followErr(followErr));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic expSlow(input int v);
    return v > 0 && v * 100 <= ThreshReset * (100 - HystPercent);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= {16'h0, d};
    do begin @(posedge clk_sys); n++; end while (ack !== 1'b1 && n < 50);
    q = rdat;
    if (n >= 50) begin
      failures++;
      tally_and_finish();
    end
    cyc <= 0; stb <= 0;
    @(posedge clk_sys);
  endtask
  task automatic speed(input logic signed [15:0] v, input logic e);
    speedCmd <= v;
    repeat (150) @(posedge clk_sys);
    chk(slowSpeed, e, "slow speed state");
  endtask
  task automatic restart();
    rstn <= 0;
    repeat (8) @(posedge clk_sys);
    rstn <= 1;
    @(posedge clk_sys);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #800000;
    failures++;
    tally_and_finish();
  end
  initial begin
    restart();
    wb(0, SubmodeOffset, 0); chk(q, 0, "submode reset");
    wb(0, SensorOffset, 0); chk(q, {30'h0, SensorReset}, "sensor reset");
    wb(0, ThreshOffset, 0); chk(q, {16'h0, ThreshReset}, "threshold reset");
    wb(0, 8'h20, 0); chk(q, 0, "unmapped read");
    $display("register test done");
    wb(1, SubmodeOffset, 16'h0011);
    wb(1, PowerCmdOffset, 16'h0001);
    repeat (60) @(posedge clk_sys);
    chk(opEnabled, 1, "operation enabled after alignment");
    speedCmd <= 16'sd40;
    repeat (80) @(posedge clk_sys);
    chk(closedLoop, 1, "closed loop after index");
    wb(0, StatusOffset, 0); chk(q, {16'h0, StatOpEnabled} | (32'h1 << StatClosedLoopBit), "status word");
    $display("alignment test done");
    wb(1, SubmodeOffset, 16'h0091);
    repeat (4) begin
      rnd = lfsr(rnd);
      speed(16'(rnd[5:0]) + 16'sd1, expSlow(rnd[5:0] + 1));
      chk(vectorCtrl, 0, "vector control idle in slow speed");
      errCmd <= 1;
      repeat (3) @(posedge clk_sys);
      chk(vectorCtrl, 1, "vector control on error");
      errCmd <= 0;
    end
    wb(1, SensorOffset, 16'h0001);
    repeat (3) @(posedge clk_sys);
    chk(slowSpeed, 0, "slow speed without encoder");
    wb(1, SensorOffset, 16'h0002);
    speed(16'sd100, 1);
    wb(0, StatusOffset, 0); chk(q, {16'h0, StatOpEnabled}, "status word in slow speed");
    // Clock enable low must freeze the slow-speed state although the motor speeds up.
    ce <= 0;
    speedCmd <= 16'sd200;
    repeat (150) @(posedge clk_sys);
    chk(slowSpeed, 1, "state frozen by clock enable");
    ce <= 1;
    speed(16'sd200, 0);
    wb(0, SpeedOffset, 0); chk(q, 32'hc8, "filtered speed");
    speed(16'sd100, 0);
    speed(16'sd0, 0);
    chk(closedLoop, 1, "closed loop at rest");
    $display("slow speed test done");
    restart();
    setup <= 1;
    @(posedge clk_sys);
    setup <= 0;
    @(posedge clk_sys);
    wb(0, SubmodeOffset, 0); chk(q, 32'h0101, "auto setup sets enable");
    chk(closedLoop, 0, "open loop before index");
    speedCmd <= 16'sd40;
    repeat (80) @(posedge clk_sys);
    chk(closedLoop, 1, "closed loop once index seen");
    speedCmd <= 16'sd0;
    wb(1, SensorOffset, 16'h0001);
    wb(1, PowerCmdOffset, 16'h0001);
    repeat (5) @(posedge clk_sys);
    chk({closedLoop, commutHall, alignDrive}, 3'b110, "hall closed loop");
    $display("hall test done");
    tally_and_finish();
  end
endmodule
bind closed_loop_mode_select closed_loop_mode_select_asserts #(.AlignCount(AlignCount)) asserts_inst (
  .clk_sys(clk_sys), .rstn(rstn), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .encDelta(encDelta), .followErr(followErr),
  .closedLoop(closedLoop), .slowSpeed(slowSpeed), .alignDrive(alignDrive), .vectorCtrl(vectorCtrl),
  .opEnabled(opEnabled));
